// ---- design/ocpwm_pkg.sv ----
// Package for the output compare / PWM channel
package ocpwm_pkg;
    // ==========================================================
    // Register map
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_COMPARE_A = 4'h1;
    localparam logic [3:0] ADDR_COMPARE_B = 4'h2;
    localparam logic [3:0] ADDR_STATUS    = 4'h3;
    // ==========================================================
    // Control field positions and reset values
    localparam int BIT_IDLE_STOP  = 13;
    localparam int BIT_FAULT      = 4;
    localparam int BIT_TIME_BASE  = 3;
    localparam int MODE_HI        = 2;
    localparam logic [15:0] CONTROL_WMASK = 16'h200f;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;

    // ==========================================================
    // Compare modes
    localparam logic [2:0] MODE_OFF        = 3'h0;
    localparam logic [2:0] MODE_SET_HIGH   = 3'h1;
    localparam logic [2:0] MODE_SET_LOW    = 3'h2;
    localparam logic [2:0] MODE_TOGGLE     = 3'h3;
    localparam logic [2:0] MODE_ONE_PULSE  = 3'h4;
    localparam logic [2:0] MODE_PULSES     = 3'h5;
    localparam logic [2:0] MODE_PWM        = 3'h6;
    localparam logic [2:0] MODE_PWM_FAULT  = 3'h7;

    typedef struct packed {
        logic        idle_stop_select;
        logic        time_base_select;
        logic [2:0]  compare_mode_field;
    } ocpwm_ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] period;
    } ocpwm_timer_t;
endpackage

// ---- design/ocpwm_sync.sv ----
// Two-flop synchroniser for a pin level
`timescale 1ns/1ps
module ocpwm_sync (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic stage1;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // Released level of the active-low pin, so no false fault
            stage1 <= 1'b1;
            dout   <= 1'b1;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // ocpwm_sync

// ---- design/ocpwm_channel.sv ----
// Output compare / PWM channel with its register port
// How it works
// - Idle-stop bit 13 set freezes the pin and compare events while the CPU idles, but the fault flag still updates
// - Fault flag bit 4 is set by hardware only, a control write clears it once the fault input is released
// - Fault flag can still be set in the first cycle after leaving mode 111, then stays zero in every mode other than 111
// - Time base bit 3: one picks timer 3, zero picks timer 2
// - Mode 111 is PWM with fault input watched
// - Mode 110 is PWM with fault input ignored
// - Mode 101 starts low, then one pulse every timer period
// - Mode 100 starts low, then exactly one pulse
// - Mode 011 inverts the pin on each compare A match
// - Mode 010 starts high, match forces the pin low
// - Mode 001 starts low, match forces the pin high
// - Mode 000 disables the channel, pin held low
// - Bits 15:14 and 12:5 read zero and ignore writes
`timescale 1ns/1ps
module ocpwm_channel
    import ocpwm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [3:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         reg_write,
    input  wire logic         reg_read,
    output logic      [15:0]  reg_rdata,
    input  wire ocpwm_timer_t timer2,
    input  wire ocpwm_timer_t timer3,
    input  wire logic         cpu_idle,
    input  wire logic         fault_pin_n,
    output logic              compare_output_pin,
    output logic              compare_event
);
    // ==========================================================
    // Registers
    ocpwm_ctrl_t ctrl;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic        fault_status_flag;
    logic        pulse_done;
    logic        fault_sync_n;
    logic        mode_write;

    ocpwm_sync u_fault_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (fault_pin_n),
        .dout     (fault_sync_n)
    );

    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m == MODE_PWM) || (m == MODE_PWM_FAULT);
    endfunction

    function automatic logic [15:0] control_word(input ocpwm_ctrl_t c,
                                                 input logic f);
        logic [15:0] w;
        w = 16'h0000;
        w[BIT_IDLE_STOP]  = c.idle_stop_select;
        w[BIT_FAULT]      = f;
        w[BIT_TIME_BASE]  = c.time_base_select;
        w[MODE_HI:0]      = c.compare_mode_field;
        control_word = w;
    endfunction

    assign mode_write = reg_write && (reg_addr == ADDR_CONTROL);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl <= '0;
        end else if (mode_write) begin
            // Only bits 13, 3 and 2:0 hold state
            ctrl.idle_stop_select   <= reg_wdata[BIT_IDLE_STOP];
            ctrl.time_base_select   <= reg_wdata[BIT_TIME_BASE];
            ctrl.compare_mode_field <= reg_wdata[MODE_HI:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            compare_a <= COMPARE_RESET;
            compare_b <= COMPARE_RESET;
        end else if (reg_write) begin
            if (reg_addr == ADDR_COMPARE_A)
                compare_a <= reg_wdata;
            if (reg_addr == ADDR_COMPARE_B)
                compare_b <= reg_wdata;
        end
    end

    // ==========================================================
    // Time base and compare events
    logic [15:0] tb_count;
    logic [15:0] tb_period;
    logic        run;
    logic        match_a;
    logic        match_b;
    logic        period_end;

    always_comb begin
        tb_count  = ctrl.time_base_select ? timer3.count  : timer2.count;
        tb_period = ctrl.time_base_select ? timer3.period : timer2.period;
    end

    assign run        = !(ctrl.idle_stop_select && cpu_idle);
    assign match_a    = run && (tb_count == compare_a);
    assign match_b    = run && (tb_count == compare_b);
    assign period_end = run && (tb_count == tb_period);

    // ==========================================================
    // Fault flag
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_status_flag <= 1'b0;
        end else if (ctrl.compare_mode_field != MODE_PWM_FAULT) begin
            fault_status_flag <= 1'b0;
        end else if (!fault_sync_n) begin
            fault_status_flag <= 1'b1;
        end else if (mode_write) begin
            fault_status_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Output pin
    logic next_pin;
    logic next_done;

    always_comb begin
        next_pin  = compare_output_pin;
        next_done = pulse_done;
        case (ctrl.compare_mode_field)
            MODE_OFF: next_pin = 1'b0;
            MODE_SET_HIGH: if (match_a) next_pin = 1'b1;
            MODE_SET_LOW: if (match_a) next_pin = 1'b0;
            MODE_TOGGLE: if (match_a) next_pin = !compare_output_pin;
            MODE_ONE_PULSE: begin
                if (match_a && !pulse_done)
                    next_pin = 1'b1;
                else if (match_b && compare_output_pin) begin
                    next_pin  = 1'b0;
                    next_done = 1'b1;
                end
            end
            MODE_PULSES: begin
                if (match_a)
                    next_pin = 1'b1;
                else if (match_b)
                    next_pin = 1'b0;
            end
            MODE_PWM, MODE_PWM_FAULT: begin
                // Mode 110 must not see a flag left over from 111
                if (ctrl.compare_mode_field == MODE_PWM_FAULT &&
                    (fault_status_flag || !fault_sync_n))
                    next_pin = 1'b0;
                else if (period_end)
                    next_pin = (compare_a != 16'h0000);
                else if (match_a)
                    next_pin = 1'b0;
            end
            default: next_pin = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            compare_output_pin <= 1'b0;
            pulse_done         <= 1'b0;
        end else if (mode_write) begin
            // Initial level of the new mode
            compare_output_pin <= (reg_wdata[MODE_HI:0] == MODE_SET_LOW);
            pulse_done         <= 1'b0;
        end else if (run) begin
            compare_output_pin <= next_pin;
            pulse_done         <= next_done;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst)
            compare_event <= 1'b0;
        else
            compare_event <= match_a &&
                             (ctrl.compare_mode_field != MODE_OFF);
    end

    // ==========================================================
    // Read port
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_CONTROL:
                    reg_rdata <= control_word(ctrl, fault_status_flag);
                ADDR_COMPARE_A: reg_rdata <= compare_a;
                ADDR_COMPARE_B: reg_rdata <= compare_b;
                ADDR_STATUS: reg_rdata <= {14'h0000, pulse_done,
                                           compare_output_pin};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // Checks
    sequence one_pulse_done_s;
        ctrl.compare_mode_field == MODE_ONE_PULSE && pulse_done;
    endsequence

    sequence pwm_fault_live_s;
        ctrl.compare_mode_field == MODE_PWM_FAULT && !mode_write;
    endsequence

    fault_only_pwm_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl.compare_mode_field != MODE_PWM_FAULT |=> !fault_status_flag)
        else $error("fault flag set outside mode 111");

    fault_sets_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PWM_FAULT && !fault_sync_n &&
         !mode_write) |=> fault_status_flag)
        else $error("fault flag not set");

    fault_sticky_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (pwm_fault_live_s and fault_status_flag) |=> fault_status_flag)
        else $error("fault flag cleared without a mode write");

    fault_clears_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PWM_FAULT && fault_sync_n &&
         mode_write) |=> !fault_status_flag)
        else $error("fault flag kept after mode rewrite");

    fault_holds_pin_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (pwm_fault_live_s and fault_status_flag && run) |=>
        !compare_output_pin)
        else $error("pin active during fault");

    pwm_fault_low_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (pwm_fault_live_s and !fault_sync_n && run) |=>
        !compare_output_pin)
        else $error("fault input did not force pin low");

    pwm_period_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PWM && period_end &&
         compare_a != 16'h0000 && !mode_write) |=> compare_output_pin)
        else $error("pwm period did not raise pin");

    pwm_fall_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PWM && match_a && !period_end &&
         !mode_write) |=> !compare_output_pin)
        else $error("pwm duty match did not lower pin");

    idle_freeze_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (!run && !mode_write) |=> $stable(compare_output_pin))
        else $error("pin moved while idle stopped");

    idle_no_event_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.idle_stop_select && cpu_idle) |=> !compare_event)
        else $error("compare event while idle stopped");

    tb2_select_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_SET_HIGH && run && !mode_write &&
         !ctrl.time_base_select && timer2.count == compare_a) |=>
        compare_output_pin)
        else $error("timer 2 match missed");

    tb3_select_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_SET_LOW && run && !mode_write &&
         ctrl.time_base_select && timer3.count == compare_a) |=>
        !compare_output_pin)
        else $error("timer 3 match missed");

    off_low_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_OFF && !mode_write) |=>
        !compare_output_pin)
        else $error("pin driven in disabled mode");

    event_off_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        ctrl.compare_mode_field == MODE_OFF |=> !compare_event)
        else $error("compare event in disabled mode");

    toggle_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_TOGGLE && match_a && !mode_write)
        |=> compare_output_pin != $past(compare_output_pin))
        else $error("toggle missed");

    init_high_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (mode_write && reg_wdata[MODE_HI:0] == MODE_SET_LOW) |=>
        compare_output_pin)
        else $error("mode 010 did not start high");

    init_low_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (mode_write && reg_wdata[MODE_HI:0] != MODE_SET_LOW) |=>
        !compare_output_pin)
        else $error("new mode did not start low");

    set_high_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_SET_HIGH && match_a &&
         !mode_write) |=> compare_output_pin)
        else $error("match did not force pin high");

    one_pulse_rise_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_ONE_PULSE && match_a &&
         !pulse_done && !mode_write) |=> compare_output_pin)
        else $error("single pulse did not rise");

    single_pulse_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (one_pulse_done_s and !mode_write) |=> !compare_output_pin)
        else $error("second pulse in one-pulse mode");

    pulses_rise_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PULSES && match_a &&
         !mode_write) |=> compare_output_pin)
        else $error("continuous pulse did not rise");

    pulses_fall_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (ctrl.compare_mode_field == MODE_PULSES && match_b && !match_a &&
         !mode_write) |=> !compare_output_pin)
        else $error("continuous pulse did not fall");

    reserved_zero_a : assert property (
        @(posedge core_clk) disable iff (sys_rst)
        (reg_read && reg_addr == ADDR_CONTROL) |=>
        (reg_rdata & ~(CONTROL_WMASK | 16'h0010)) == 16'h0000)
        else $error("reserved control bits read nonzero");
endmodule // ocpwm_channel

// ---- sim/ocpwm_partner.sv ----
// Timer pair and fault pin model for the compare channel bench
`timescale 1ns/1ps
module ocpwm_partner
    import ocpwm_pkg::*;
#(
    parameter logic [15:0] PER2 = 16'h0013,
    parameter logic [15:0] PER3 = 16'h000b
) (
    input  wire logic    core_clk,
    input  wire logic    sys_rst,
    input  wire logic    fault_on,
    output ocpwm_timer_t timer2,
    output ocpwm_timer_t timer3,
    output logic         fault_pin_n
);
    logic [15:0] cnt2;
    logic [15:0] cnt3;
    // ====
    // Time bases
    // Free running, so every compare value up to the period recurs once a period
    always_ff @(posedge core_clk) begin
        cnt2 <= (sys_rst || cnt2 == PER2) ? 16'h0000 : cnt2 + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        cnt3 <= (sys_rst || cnt3 == PER3) ? 16'h0000 : cnt3 + 16'h0001;
    end
    assign timer2 = '{count: cnt2, period: PER2};
    assign timer3 = '{count: cnt3, period: PER3};
    // ====
    // Fault pin, pulled up on the board, so released reads high
    assign fault_pin_n = ~fault_on;
endmodule // ocpwm_partner

// ---- sim/tb_output_compare_pwm_channel.sv ----
// Self-checking bench for the output compare / PWM channel
`timescale 1ns/1ps
module tb_output_compare_pwm_channel import ocpwm_pkg::*;;
    logic         core_clk  = 1'b0;
    logic         sys_rst   = 1'b1;
    logic [3:0]   reg_addr  = 4'h0;
    logic [15:0]  reg_wdata = 16'h0000;
    logic         reg_write = 1'b0;
    logic         reg_read  = 1'b0;
    logic         cpu_idle  = 1'b0;
    logic         fault_on  = 1'b0;
    logic [15:0]  reg_rdata;
    ocpwm_timer_t timer2;
    ocpwm_timer_t timer3;
    logic         fault_pin_n;
    logic         compare_output_pin;
    logic         compare_event;
    logic         p;
    int           err_count = 0;
    int           checked   = 0;
    int           cycles    = 0;

    ocpwm_channel i_ocpwm_channel (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .timer2(timer2), .timer3(timer3), .cpu_idle(cpu_idle),
        .fault_pin_n(fault_pin_n),
        .compare_output_pin(compare_output_pin),
        .compare_event(compare_event)
    );
    ocpwm_partner i_ocpwm_partner (
        .core_clk(core_clk), .sys_rst(sys_rst), .fault_on(fault_on),
        .timer2(timer2), .timer3(timer3), .fault_pin_n(fault_pin_n)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // ====
    // Checking and bus tasks
    task automatic final_report();
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pchk(input logic e);
        chk({15'h0, compare_output_pin}, {15'h0, e});
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Prev holds the selected count in the cycle before the pin moved
    task automatic wait_pin(input logic e, input logic t,
                            input logic [15:0] a);
        logic [15:0] prev;
        prev = 16'hffff;
        #1;
        for (int i = 0; i < 64; i++) begin
            if (compare_output_pin === e) break;
            prev = t ? timer3.count : timer2.count;
            @(posedge core_clk);
            #1;
        end
        pchk(e);
        chk(prev, a);
    endtask
    // Longer than either timer period, so any stray match shows
    task automatic hold_pin(input logic e, input logic ev);
        repeat (24) begin
            @(posedge core_clk);
            #1 chk({14'h0, ev & compare_event, compare_output_pin},
                   {15'h0, e});
        end
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ADDR_CONTROL, CONTROL_RESET);
        rd(4'h9, 16'h0000);
        wr(ADDR_CONTROL, 16'hfff8);
        rd(ADDR_CONTROL, 16'h2008);
        wr(ADDR_COMPARE_A, 16'h0007);
        wr(ADDR_CONTROL, 16'h000a);
        #1 pchk(1'b1);
        wait_pin(1'b0, 1'b1, 16'h0007);
        wr(ADDR_COMPARE_A, 16'h000f);
        wr(ADDR_CONTROL, 16'h0001);
        #1 pchk(1'b0);
        wait_pin(1'b1, 1'b0, 16'h000f);
        wr(ADDR_CONTROL, 16'h0003);
        #1 p = compare_output_pin;
        wait_pin(~p, 1'b0, 16'h000f);
        chk({15'h0, compare_event}, 16'h0001);
        wait_pin(p, 1'b0, 16'h000f);
        wr(ADDR_CONTROL, 16'h2003);
        cpu_idle <= 1'b1;
        #1 p = compare_output_pin;
        hold_pin(p, 1'b1);
        wr(ADDR_CONTROL, 16'h0003);
        #1 p = compare_output_pin;
        wait_pin(~p, 1'b0, 16'h000f);
        @(posedge core_clk);
        cpu_idle <= 1'b0;
        wr(ADDR_COMPARE_A, 16'h0005);
        wr(ADDR_COMPARE_B, 16'h0009);
        wr(ADDR_CONTROL, 16'h0004);
        #1 pchk(1'b0);
        wait_pin(1'b1, 1'b0, 16'h0005);
        wait_pin(1'b0, 1'b0, 16'h0009);
        hold_pin(1'b0, 1'b0);
        rd(ADDR_STATUS, 16'h0002);
        wr(ADDR_CONTROL, 16'h0005);
        wait_pin(1'b1, 1'b0, 16'h0005);
        wait_pin(1'b0, 1'b0, 16'h0009);
        wait_pin(1'b1, 1'b0, 16'h0005);
        wr(ADDR_CONTROL, 16'h0000);
        hold_pin(1'b0, 1'b1);
        @(posedge core_clk);
        fault_on <= 1'b1;
        wr(ADDR_CONTROL, 16'h0006);
        wait_pin(1'b1, 1'b0, 16'h0013);
        wait_pin(1'b0, 1'b0, 16'h0005);
        rd(ADDR_CONTROL, 16'h0006);
        wr(ADDR_CONTROL, 16'h0007);
        hold_pin(1'b0, 1'b0);
        rd(ADDR_CONTROL, 16'h0017);
        wr(ADDR_CONTROL, 16'h0007);
        rd(ADDR_CONTROL, 16'h0017);
        @(posedge core_clk);
        fault_on <= 1'b0;
        hold_pin(1'b0, 1'b0);
        rd(ADDR_CONTROL, 16'h0017);
        wr(ADDR_CONTROL, 16'h0007);
        rd(ADDR_CONTROL, 16'h0007);
        wait_pin(1'b1, 1'b0, 16'h0013);
        wait_pin(1'b0, 1'b0, 16'h0005);
        final_report();
    end
endmodule // tb_output_compare_pwm_channel
